// ### tcc_pkg.sv
/*
  tcc_pkg: constants for the 16-bit capture/compare timer.
  assumes: a plain register port, one clock at 50 MHz.
*/
package tcc_pkg;
  // ==========================================
  // register offsets
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_CCCTRL = 3'h1;
  localparam logic [2:0] ADDR_PRESC = 3'h2;
  localparam logic [2:0] ADDR_COUNT = 3'h3;
  localparam logic [2:0] ADDR_CMPA = 3'h4;
  localparam logic [2:0] ADDR_CCB = 3'h5;
  // ==========================================
  // mode control fields
  localparam int MODE_OVF_BIT = 0;
  localparam int MODE_OP_LO = 2;
  localparam int MODE_OP_HI = 3;
  localparam logic [1:0] OP_STOP = 2'h0;
  localparam logic [1:0] OP_FREE = 2'h1;
  localparam logic [1:0] OP_EDGE_CLR = 2'h2;
  // capture/compare control fields
  localparam int CC_B_CAPTURE_BIT = 0;
  localparam int CC_A_TRIG_BIT = 1;
  localparam int CC_A_CAPTURE_BIT = 2;
  // prescaler fields: edge select and clock divider select
  localparam int PR_ES_LO = 4;
  localparam int PR_ES_HI = 5;
  localparam int PR_DIV_LO = 0;
  localparam int PR_DIV_HI = 2;
  localparam logic [1:0] ES_FALL = 2'h0;
  localparam logic [1:0] ES_RISE = 2'h1;
  localparam logic [1:0] ES_BOTH = 2'h3;
  // ==========================================
  // counter constants
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// ### tcc_pulse_src.sv
/*
  tcc_pulse_src: pulse source on the timer input pin.
  assumes: the testbench calls drive; one clock.
*/
`timescale 1ns/10ps
module tcc_pulse_src (
  // clock
  input wire logic clock_i,
  // pin
  output logic pin_o
);
  // ==========================================
  // pin starts low, so no edge is seen at start
  initial pin_o = 1'b0;
  // set a level just after an edge and hold it n clocks
  task automatic drive(input logic lvl, input int n);
    @(posedge clock_i);
    pin_o <= lvl;
    repeat (n) @(posedge clock_i);
  endtask
endmodule // tcc_pulse_src

// ### tcc_timer.sv
/*
  tcc_timer: 16-bit up-counter, compare a, capture/compare b, overflow flag,
  free-running and edge clear-and-start modes, pin edge filter.
  assumes: timer_input_pin_i is asynchronous; software keeps the far-side rules.
*/
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps
module tcc_timer (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_hi_i,
  input wire logic [7:0] wdata_lo_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // timer pin
  input wire logic timer_input_pin_i,
  // events
  output logic match_irq_a_o,
  output logic match_capture_irq_b_o
);

  // ==========================================
  // state
  typedef struct packed {
    logic [1:0] sync;
    logic [1:0] samp;
    logic filt;
    logic [7:0] mode;
    logic [7:0] ccctrl;
    logic [7:0] presc;
    logic [15:0] count;
    logic [15:0] cmpa;
    logic [15:0] ccb;
    logic [6:0] div;
    logic irqa;
    logic irqb;
    logic [15:0] rdata;
  } tcc_state_t;

  tcc_state_t st_reg;
  tcc_state_t st_next;

  // count tick from divider select: 2^sel cycles
  function automatic logic tick_of(input logic [6:0] d, input logic [2:0] sel);
    logic t;
    t = 1'b1;
    for (int i = 0; i < 7; i++)
      if (i < int'(sel) && d[i] == 1'b0)
        t = 1'b0;
    return t;
  endfunction

  logic [1:0] op;
  logic [1:0] es;
  logic tick;
  logic rise;
  logic fall;
  logic valid_edge;
  logic opp_edge;
  logic running;
  logic ovf_set;
  logic ovf_wr;

  // ==========================================
  // decode
  always_comb
  begin
    op = st_reg.mode[tcc_pkg::MODE_OP_HI:tcc_pkg::MODE_OP_LO];
    es = st_reg.presc[tcc_pkg::PR_ES_HI:tcc_pkg::PR_ES_LO];
    running = (op == tcc_pkg::OP_FREE) || (op == tcc_pkg::OP_EDGE_CLR);
    tick = running && tick_of(st_reg.div, st_reg.presc[tcc_pkg::PR_DIV_HI:tcc_pkg::PR_DIV_LO]);
    // while running, filtered level changes only after two equal samples
    rise = (st_reg.samp == 2'h3) && !st_reg.filt;
    fall = (st_reg.samp == 2'h0) && st_reg.filt;
    case (es)
      tcc_pkg::ES_FALL: valid_edge = fall;
      tcc_pkg::ES_RISE: valid_edge = rise;
      tcc_pkg::ES_BOTH: valid_edge = rise || fall;
      default: valid_edge = 1'b0;
    endcase
    case (es)
      tcc_pkg::ES_FALL: opp_edge = rise;
      tcc_pkg::ES_RISE: opp_edge = fall;
      default: opp_edge = 1'b0;
    endcase
    valid_edge = valid_edge && running;
    opp_edge = opp_edge && running;
    // a wrap on this tick sets the flag; a mode write keeps it only if bit 0 is written 1
    ovf_set = tick && (st_reg.count == tcc_pkg::COUNT_MAX);
    ovf_wr = (wdata_lo_i[tcc_pkg::MODE_OVF_BIT] & st_reg.mode[tcc_pkg::MODE_OVF_BIT]) | ovf_set;
  end

  // ==========================================
  // next state
  always_comb
  begin
    st_next = st_reg;
    st_next.sync = {st_reg.sync[0], timer_input_pin_i};
    st_next.irqa = 1'b0;
    st_next.irqb = 1'b0;
    st_next.rdata = tcc_pkg::COUNT_ZERO;
    // edge filter samples on the count clock
    if (tick)
    begin
      st_next.samp = {st_reg.samp[0], st_reg.sync[1]};
      if (rise || fall)
        st_next.filt = !st_reg.filt;
    end
    // stopped: filter follows the pin, so a start never sees a stale edge
    if (!running)
    begin
      st_next.samp = {2{st_reg.sync[1]}};
      st_next.filt = st_reg.sync[1];
    end
    // divider restarts on every start, so the first tick comes a full period later
    st_next.div = running ? st_reg.div + 7'h01 : 7'h00;
    if (tick)
    begin
      st_next.count = st_reg.count + 16'h0001;
      if (ovf_set)
        st_next.mode[tcc_pkg::MODE_OVF_BIT] = 1'b1;
      // compare matches keep the count
      if (st_reg.count == st_reg.cmpa && !st_reg.ccctrl[tcc_pkg::CC_A_CAPTURE_BIT])
        st_next.irqa = 1'b1;
      if (st_reg.count == st_reg.ccb && !st_reg.ccctrl[tcc_pkg::CC_B_CAPTURE_BIT])
        st_next.irqb = 1'b1;
      if (op == tcc_pkg::OP_EDGE_CLR && opp_edge && st_reg.ccctrl[tcc_pkg::CC_A_CAPTURE_BIT])
      begin
        st_next.cmpa = st_reg.count;
        st_next.irqa = 1'b1;
      end
      if (valid_edge && st_reg.ccctrl[tcc_pkg::CC_B_CAPTURE_BIT])
      begin
        st_next.ccb = st_reg.count;
        st_next.irqb = 1'b1;
      end
      if (op == tcc_pkg::OP_EDGE_CLR && valid_edge)
        st_next.count = tcc_pkg::COUNT_ZERO;
    end
    // register writes
    if (wr_i)
    begin
      case (addr_i)
        tcc_pkg::ADDR_MODE:
        begin
          // overflow set wins over a software clear; writing 1 never sets it
          st_next.mode = wdata_lo_i;
          st_next.mode[tcc_pkg::MODE_OVF_BIT] = ovf_wr;
          if (wdata_lo_i[tcc_pkg::MODE_OP_HI:tcc_pkg::MODE_OP_LO] == tcc_pkg::OP_STOP)
            st_next.count = tcc_pkg::COUNT_ZERO;
        end
        tcc_pkg::ADDR_CCCTRL: st_next.ccctrl = wdata_lo_i;
        tcc_pkg::ADDR_PRESC: st_next.presc = wdata_lo_i;
        tcc_pkg::ADDR_CMPA: st_next.cmpa = {wdata_hi_i, wdata_lo_i};
        tcc_pkg::ADDR_CCB: st_next.ccb = {wdata_hi_i, wdata_lo_i};
        default: ;
      endcase
    end
    if (op == tcc_pkg::OP_STOP)
      st_next.count = tcc_pkg::COUNT_ZERO;
    // register reads
    if (rd_i)
    begin
      case (addr_i)
        tcc_pkg::ADDR_MODE: st_next.rdata = {tcc_pkg::BYTE_ZERO, st_reg.mode};
        tcc_pkg::ADDR_CCCTRL: st_next.rdata = {tcc_pkg::BYTE_ZERO, st_reg.ccctrl};
        tcc_pkg::ADDR_PRESC: st_next.rdata = {tcc_pkg::BYTE_ZERO, st_reg.presc};
        tcc_pkg::ADDR_COUNT: st_next.rdata = st_reg.count;
        tcc_pkg::ADDR_CMPA: st_next.rdata = st_reg.cmpa;
        tcc_pkg::ADDR_CCB: st_next.rdata = st_reg.ccb;
        default: st_next.rdata = tcc_pkg::COUNT_ZERO;
      endcase
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // outputs
  assign rdata_o = st_reg.rdata;
  assign match_irq_a_o = st_reg.irqa;
  assign match_capture_irq_b_o = st_reg.irqb;

  // ==========================================
  // checks
  AST_MATCH_A: assert property (@(posedge clock_i) disable iff (rst_i)
    (tick && !wr_i && st_reg.count == st_reg.cmpa && !st_reg.ccctrl[tcc_pkg::CC_A_CAPTURE_BIT]
     && !(op == tcc_pkg::OP_EDGE_CLR && valid_edge)) |=> (match_irq_a_o && st_reg.count == $past(st_reg.count) + 16'h0001))
    else $error("match a missed or count changed");
  AST_MATCH_B: assert property (@(posedge clock_i) disable iff (rst_i)
    (tick && st_reg.count == st_reg.ccb && !st_reg.ccctrl[tcc_pkg::CC_B_CAPTURE_BIT]) |=> match_capture_irq_b_o)
    else $error("match b missed");
  AST_CAPTURE_B: assert property (@(posedge clock_i) disable iff (rst_i)
    (tick && valid_edge && st_reg.ccctrl[tcc_pkg::CC_B_CAPTURE_BIT] && !wr_i) |=> (st_reg.ccb == $past(st_reg.count)))
    else $error("capture b wrong");
  AST_WRAP: assert property (@(posedge clock_i) disable iff (rst_i)
    (tick && op == tcc_pkg::OP_FREE && st_reg.count == tcc_pkg::COUNT_MAX && !wr_i)
      |=> (st_reg.mode[tcc_pkg::MODE_OVF_BIT] && st_reg.count == tcc_pkg::COUNT_ZERO))
    else $error("wrap or overflow wrong");
  AST_FLAG_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
    (st_reg.mode[tcc_pkg::MODE_OVF_BIT] && !(wr_i && addr_i == tcc_pkg::ADDR_MODE))
      |=> st_reg.mode[tcc_pkg::MODE_OVF_BIT])
    else $error("overflow flag lost");
  AST_EDGE_CLEAR: assert property (@(posedge clock_i) disable iff (rst_i)
    (tick && op == tcc_pkg::OP_EDGE_CLR && valid_edge && !wr_i) |=> (st_reg.count == tcc_pkg::COUNT_ZERO))
    else $error("edge clear missed");
  AST_STOP: assert property (@(posedge clock_i) disable iff (rst_i)
    (op == tcc_pkg::OP_STOP && !wr_i) |=> (st_reg.count == tcc_pkg::COUNT_ZERO))
    else $error("stopped counter not zero");
  sequence seq_read_count;
    rd_i && addr_i == tcc_pkg::ADDR_COUNT;
  endsequence
  AST_READ_COUNT: assert property (@(posedge clock_i) disable iff (rst_i)
    seq_read_count |=> (rdata_o == $past(st_reg.count)))
    else $error("count read wrong");
  AST_FILTER: assert property (@(posedge clock_i) disable iff (rst_i)
    (running && $changed(st_reg.filt)) |-> ($past(st_reg.samp) == {2{st_reg.filt}}))
    else $error("edge accepted without two samples");

  // ==========================================
  // sequence-built checks
  // overflow set and software clear
  sequence seq_wrap_tick;
    tick && st_reg.count == tcc_pkg::COUNT_MAX;
  endsequence
  AST_OVF_SET_WINS: assert property (@(posedge clock_i) disable iff (rst_i)
    seq_wrap_tick |=> st_reg.mode[tcc_pkg::MODE_OVF_BIT])
    else $error("overflow set lost");
  // a clear that meets a wrap in one cycle is lost on purpose
  sequence seq_flag_clear;
    wr_i && addr_i == tcc_pkg::ADDR_MODE && !wdata_lo_i[tcc_pkg::MODE_OVF_BIT] && !ovf_set;
  endsequence
  AST_FLAG_CLEAR: assert property (@(posedge clock_i) disable iff (rst_i)
    seq_flag_clear |=> !st_reg.mode[tcc_pkg::MODE_OVF_BIT])
    else $error("overflow flag not cleared by a zero write");
  // counting steps only on ticks
  sequence seq_free_tick;
    tick && op == tcc_pkg::OP_FREE && !wr_i;
  endsequence
  AST_FREE_COUNT: assert property (@(posedge clock_i) disable iff (rst_i)
    seq_free_tick |=> (st_reg.count == $past(st_reg.count) + 16'h0001))
    else $error("free-running count did not step");
  AST_DIV_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
    (running && !tick && !wr_i) |=> $stable(st_reg.count))
    else $error("count moved between ticks");
  AST_EDGE_NO_CLEAR: assert property (@(posedge clock_i) disable iff (rst_i)
    (tick && op == tcc_pkg::OP_EDGE_CLR && !valid_edge && !wr_i) |=> (st_reg.count == $past(st_reg.count) + 16'h0001))
    else $error("edge mode count did not step");
  // opposite edge capture into a
  sequence seq_opp_capture;
    tick && op == tcc_pkg::OP_EDGE_CLR && opp_edge && st_reg.ccctrl[tcc_pkg::CC_A_CAPTURE_BIT] && !wr_i;
  endsequence
  AST_CAPTURE_A: assert property (@(posedge clock_i) disable iff (rst_i)
    seq_opp_capture |=> (match_irq_a_o && st_reg.cmpa == $past(st_reg.count)))
    else $error("opposite edge capture wrong");
  // b set for capture gives no compare match and holds its value
  sequence seq_b_capture_idle;
    st_reg.ccctrl[tcc_pkg::CC_B_CAPTURE_BIT] && !(tick && valid_edge);
  endsequence
  AST_B_NO_COMPARE: assert property (@(posedge clock_i) disable iff (rst_i)
    seq_b_capture_idle |=> !match_capture_irq_b_o)
    else $error("b in capture raised a match");
  AST_B_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
    (st_reg.ccctrl[tcc_pkg::CC_B_CAPTURE_BIT] && !(tick && valid_edge) && !(wr_i && addr_i == tcc_pkg::ADDR_CCB))
      |=> $stable(st_reg.ccb))
    else $error("b capture value moved");
  // reset and read port; no disable on the first, it watches the release itself
  AST_RESET_STATE: assert property (@(posedge clock_i)
    $fell(rst_i) |-> (st_reg.count == tcc_pkg::COUNT_ZERO && op == tcc_pkg::OP_STOP && !st_reg.mode[tcc_pkg::MODE_OVF_BIT]))
    else $error("state after reset wrong");
  AST_RDATA_IDLE: assert property (@(posedge clock_i) disable iff (rst_i)
    !rd_i |=> (rdata_o == tcc_pkg::COUNT_ZERO))
    else $error("read data stood too long");
endmodule // tcc_timer

// ### testbench.sv
/*
  testbench: register-level tests of tcc_timer.
  assumes: tcc_pulse_src drives the pin; 50 MHz clock.
*/
`timescale 1ns/10ps
module testbench;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic pin;
  logic irq_a;
  logic irq_b;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  int na = 0;
  int nb = 0;
  logic [15:0] v;
  logic [15:0] w;
  logic [1:0] es [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int nr [4] = '{0, 1, 1, 0};
  int nf [4] = '{1, 0, 1, 0};
  logic [15:0] x;
  logic [15:0] y;
  // ==========================================
  // clock, cycle ceiling and event counts
  always #10 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    na <= na + int'(irq_a === 1'b1);
    nb <= nb + int'(irq_b === 1'b1);
    if (cyc == 80000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  // design and pin source
  tcc_timer dut_u (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_hi_i(wdata[15:8]),
    .wdata_lo_i(wdata[7:0]), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_input_pin_i(pin),
    .match_irq_a_o(irq_a), .match_capture_irq_b_o(irq_b));
  tcc_pulse_src src_u (.clock_i(clock_i), .pin_o(pin));
  // ==========================================
  // register port cycles and comparison
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  // one read, or two back to back when two is set
  task automatic rd(input logic [2:0] a, output logic [15:0] d0, output logic [15:0] d1, input bit two);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= two;
    @(negedge clock_i);
    d0 = rdata_o;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    d1 = rdata_o;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // bounded wait for exactly one event
  task automatic waitev(ref int c, input int lim, input string n);
    int s;
    s = c;
    repeat (lim) if (c == s) @(posedge clock_i);
    chk(n, 16'h0001, 16'(c - s));
  endtask
  // drive a pin level and count the events it caused
  task automatic edge_chk(input logic l, input int h, ref int c, input int e, input string n);
    int s;
    s = c;
    src_u.drive(l, h);
    chk(n, 16'(e), 16'(c - s));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // test sequence
  initial
  begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(tcc_pkg::ADDR_MODE, v, w, 0);
    chk("mode", 16'h0000, v);
    chk("rdata idle", 16'h0000, w);
    rd(tcc_pkg::ADDR_COUNT, v, w, 0);
    chk("count", 16'h0000, v);
    rd(3'h6, v, w, 0);
    chk("unmapped", 16'h0000, v);
    $display("test reset done");
    wr(tcc_pkg::ADDR_CMPA, 16'h0005);
    wr(tcc_pkg::ADDR_CCB, 16'h0008);
    wr(tcc_pkg::ADDR_MODE, 16'h0004);
    waitev(na, 30, "irq a");
    waitev(nb, 30, "irq b");
    rd(tcc_pkg::ADDR_COUNT, v, w, 1);
    chk("live count", v + 16'h0001, w);
    chk("count kept", 16'h0001, {15'h0, v > 16'h0008});
    $display("test compare done");
    wr(tcc_pkg::ADDR_CMPA, 16'hffff);
    waitev(na, 70000, "irq a at ffff");
    rd(tcc_pkg::ADDR_MODE, v, w, 0);
    chk("overflow", 16'h0005, v);
    rd(tcc_pkg::ADDR_COUNT, v, w, 0);
    chk("wrapped", 16'h0001, {15'h0, v < 16'h0010});
    wr(tcc_pkg::ADDR_MODE, 16'h0004);
    rd(tcc_pkg::ADDR_MODE, v, w, 0);
    chk("flag clear", 16'h0004, v);
    wr(tcc_pkg::ADDR_MODE, 16'h0000);
    rd(tcc_pkg::ADDR_COUNT, v, w, 1);
    chk("stopped", 16'h0000, v | w);
    wr(tcc_pkg::ADDR_PRESC, 16'h0002);
    wr(tcc_pkg::ADDR_MODE, 16'h0004);
    repeat (38) @(posedge clock_i);
    rd(tcc_pkg::ADDR_COUNT, v, w, 0);
    chk("divided count", 16'h0001, {15'h0, v >= 16'h0009 && v <= 16'h000a});
    $display("test overflow done");
    wr(tcc_pkg::ADDR_CCCTRL, 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      wr(tcc_pkg::ADDR_MODE, 16'h0000);
      wr(tcc_pkg::ADDR_PRESC, {10'h0, es[i], 4'h0});
      wr(tcc_pkg::ADDR_MODE, 16'h0004);
      edge_chk(1'b1, 10, nb, nr[i], "rise");
      edge_chk(1'b0, 10, nb, nf[i], "fall");
    end
    wr(tcc_pkg::ADDR_PRESC, 16'h0010);
    edge_chk(1'b1, 0, nb, 0, "glitch");
    edge_chk(1'b0, 10, nb, 0, "glitch end");
    rd(tcc_pkg::ADDR_COUNT, v, w, 0);
    edge_chk(1'b1, 10, nb, 1, "capture");
    rd(tcc_pkg::ADDR_CCB, w, x, 0);
    chk("capture value", 16'h0001, {15'h0, w > v && w < v + 16'h0010});
    // low pulse of 14 count clocks measured with both edges
    wr(tcc_pkg::ADDR_MODE, 16'h0000);
    wr(tcc_pkg::ADDR_PRESC, 16'h0030);
    wr(tcc_pkg::ADDR_MODE, 16'h0004);
    edge_chk(1'b0, 10, nb, 1, "pulse start");
    rd(tcc_pkg::ADDR_CCB, v, x, 0);
    edge_chk(1'b1, 10, nb, 1, "pulse end");
    rd(tcc_pkg::ADDR_CCB, w, x, 0);
    rd(tcc_pkg::ADDR_MODE, x, y, 0);
    chk("no overflow", 16'h0004, x);
    chk("pulse width", 16'h000e, w - v);
    wr(tcc_pkg::ADDR_PRESC, 16'h0010);
    $display("test edges done");
    src_u.drive(1'b0, 10);
    wr(tcc_pkg::ADDR_MODE, 16'h0000);
    wr(tcc_pkg::ADDR_CCCTRL, 16'h0005);
    wr(tcc_pkg::ADDR_MODE, 16'h0008);
    repeat (40) @(posedge clock_i);
    edge_chk(1'b1, 10, nb, 1, "valid edge");
    rd(tcc_pkg::ADDR_COUNT, v, w, 0);
    chk("cleared", 16'h0001, {15'h0, v < 16'h0014});
    rd(tcc_pkg::ADDR_CCB, w, x, 0);
    rd(tcc_pkg::ADDR_MODE, x, y, 0);
    chk("edge mode flag", 16'h0008, x);
    chk("cycle", 16'h0001, {15'h0, 17'(w) + 17'(x[0]) * 17'h10000 > 17'h00027});
    edge_chk(1'b0, 10, na, 1, "opposite edge");
    rd(tcc_pkg::ADDR_CMPA, w, x, 0);
    chk("width", 16'h0001, {15'h0, w > v && w < 16'h0028});
    $display("test clear and start done");
    tally_and_finish();
  end
endmodule // testbench
